// ### core/monitor_consts.svh
// constants for the monitoring mux and converter control
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH
`define MON_SEL_CFG_ADDR      8'h63
`define MON_SEL_CFG_RESET     13'h0000
`define MON_EN_BIT            12
`define MON_ISEL_MSB          11
`define MON_ISEL_LSB          6
`define MON_VSEL_MSB          5
`define MON_VSEL_LSB          0
`define MON_SEL_OFF           6'h3F
`define MON_TRIM_RESET        6'h20
`define CLK_FREQ_HZ           40000000
`define CONV_CLK_DIV          1024
`define CONV_PERIODS          14
`define RESULT_BITS           12
`endif

// ### core/monitor_mux_adc_control.sv
// monitor selector, converter clock and successive approximation control
//
// Overview of operation
// [RL1] current and voltage selectors each take their own 6-bit code
// [RL2] code 63 disables a selector, leaving its output floating
// [RL3] selector decode is one-hot, at most one switch closed
// [RL4] config bit 12 enables monitoring, bits 5..0 select voltage input
// [RL5] config bits 11..6 select the current input
// [RL6] converter clock is the 40 MHz clock divided by 1024
// [RL7] 12-bit result resolved one bit per step, msb first
// [RL8] internal start pulse becomes a start aligned to converter clock
// [RL9] active-low done flag goes low when a conversion finishes
// [RL10] six-bit trim field drives the bridge capacitor adjust
// [RL11] results go out on the normal data links, interleaved with hits
// [RL12] result read via register reads or automatic readout
// [RL13] monitoring works at any time without stalling hit data
// [RL14] a conversion takes 14 converter clock periods
// [RL15] result holds until next conversion; reads never start one
// [RL16] controller configures, enables, pulses, waits, reads, disables
// [RL17] monitoring enable is 0 after reset
// [RL18] done flag returns high on accepted start until finish
`timescale 1ns/1ps
`include "monitor_consts.svh"
module monitor_mux_adc_control
    import monitor_pkg::*;
#(
    parameter int          CODE_W   = 6,
    parameter int          RES_W    = `RESULT_BITS,
    parameter int          DIV      = `CONV_CLK_DIV,
    parameter logic [5:0]  TRIM_RST = `MON_TRIM_RESET
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_cfg_wr,
    input  wire logic [7:0]            i_cfg_addr,
    input  wire logic [12:0]           i_cfg_wdata,
    input  wire logic                  i_trim_wr,
    input  wire logic [5:0]            i_trim_wdata,
    input  wire logic                  i_start_pulse,
    input  wire logic                  i_comparator,
    input  wire logic                  i_result_rd,
    output logic [12:0]                o_cfg_rdata,
    output logic [5:0]                 o_converter_trim_cfg,
    output logic                       o_monitor_enable,
    output logic [(1<<CODE_W)-2:0]     o_current_selector_sw,
    output logic [(1<<CODE_W)-2:0]     o_voltage_selector_sw,
    output logic                       o_conv_clk_en,
    output logic                       o_converter_start,
    output logic [RES_W-1:0]           o_dac_code,
    output logic                       o_sample,
    output logic [RES_W-1:0]           o_conversion_result_reg,
    output logic                       o_conv_done_n,
    output logic                       o_result_rd_valid,
    output logic [RES_W-1:0]           o_result_rd_data
);
    localparam int DIV_W = $clog2(DIV);
    localparam int STEP_W = 4;
    localparam logic [STEP_W-1:0] LAST_STEP =
        STEP_W'(`CONV_PERIODS - 1);
    localparam logic [STEP_W-1:0] FIRST_BIT_STEP = STEP_W'(1);

    logic [12:0]        cfg_reg,     cfg_next;
    logic [5:0]         trim_reg,    trim_next;
    logic [DIV_W-1:0]   div_reg,     div_next;
    conv_state_t        state_reg,   state_next;
    logic [STEP_W-1:0]  step_reg,    step_next;
    logic [RES_W-1:0]   sar_reg,     sar_next;
    logic [RES_W-1:0]   result_reg,  result_next;
    logic               done_n_reg,  done_n_next;
    logic               start_reg,   start_next;
    logic               rdv_reg,     rdv_next;
    logic [RES_W-1:0]   rdd_reg,     rdd_next;
    logic               tick;
    logic [STEP_W-1:0]  bit_idx;

    // register storage
    always_comb begin
        cfg_next  = cfg_reg;
        trim_next = trim_reg;
        if (i_cfg_wr && i_cfg_addr == `MON_SEL_CFG_ADDR) begin
            cfg_next = i_cfg_wdata; // [RL4] [RL5]
        end
        if (i_trim_wr) begin
            trim_next = i_trim_wdata; // [RL10]
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_reg  <= `MON_SEL_CFG_RESET; // [RL17]
            trim_reg <= TRIM_RST;
        end else begin
            cfg_reg  <= cfg_next;
            trim_reg <= trim_next;
        end
    end

    assign o_cfg_rdata          = cfg_reg;
    assign o_converter_trim_cfg = trim_reg;
    assign o_monitor_enable     = cfg_reg[`MON_EN_BIT];

    one_hot_selector #(.CODE_W(CODE_W)) u_current_sel (
        .i_code   (cfg_reg[`MON_ISEL_MSB:`MON_ISEL_LSB]), // [RL1] [RL5]
        .i_enable (cfg_reg[`MON_EN_BIT]),
        .o_switch (o_current_selector_sw)
    );

    one_hot_selector #(.CODE_W(CODE_W)) u_voltage_sel (
        .i_code   (cfg_reg[`MON_VSEL_MSB:`MON_VSEL_LSB]), // [RL1] [RL4]
        .i_enable (cfg_reg[`MON_EN_BIT]),
        .o_switch (o_voltage_selector_sw)
    );

    // free-running divider; tick is the converter clock enable
    always_comb begin
        div_next = div_reg + DIV_W'(1); // [RL6]
    end

    assign tick = (div_reg == DIV_W'(DIV - 1)); // [RL6]

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign o_conv_clk_en = tick;

    // step 0 samples, steps 1..12 resolve bits, step 13 latches result
    assign bit_idx = LAST_STEP - step_reg - STEP_W'(1);

    always_comb begin
        state_next  = state_reg;
        step_next   = step_reg;
        sar_next    = sar_reg;
        result_next = result_reg;
        done_n_next = done_n_reg;
        start_next  = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // start only counts while monitoring is enabled
                if (i_start_pulse && cfg_reg[`MON_EN_BIT]) begin // [RL8]
                    state_next  = ST_ARMED;
                    done_n_next = 1'b1; // [RL18]
                end
            end
            ST_ARMED: begin
                if (tick) begin
                    start_next = 1'b1; // [RL8]
                    state_next = ST_CONVERT;
                    step_next  = '0;
                    sar_next   = '0;
                end
            end
            ST_CONVERT: begin
                if (tick) begin
                    if (step_reg >= FIRST_BIT_STEP &&
                        step_reg < LAST_STEP) begin
                        // keep trial bit if input is above dac level
                        sar_next[bit_idx] = i_comparator; // [RL7]
                        if (bit_idx != '0) begin
                            sar_next[bit_idx - STEP_W'(1)] = 1'b1;
                        end
                    end else if (step_reg == '0) begin
                        sar_next[RES_W-1] = 1'b1; // [RL7]
                    end
                    if (step_reg == LAST_STEP) begin // [RL14]
                        result_next = sar_reg; // [RL15]
                        done_n_next = 1'b0; // [RL9]
                        state_next  = ST_IDLE;
                    end else begin
                        step_next = step_reg + STEP_W'(1);
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg  <= ST_IDLE;
            step_reg   <= '0;
            sar_reg    <= '0;
            result_reg <= '0;
            done_n_reg <= 1'b1;
            start_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            step_reg   <= step_next;
            sar_reg    <= sar_next;
            result_reg <= result_next;
            done_n_reg <= done_n_next;
            start_reg  <= start_next;
        end
    end

    assign o_converter_start       = start_reg;
    assign o_dac_code              = sar_reg;
    assign o_sample = (state_reg == ST_CONVERT) && (step_reg == '0);
    assign o_conversion_result_reg = result_reg;
    assign o_conv_done_n           = done_n_reg;

    // read path feeds the service-block mux; never touches the converter
    always_comb begin
        rdv_next = i_result_rd; // [RL12] [RL15]
        rdd_next = i_result_rd ? result_reg : rdd_reg; // [RL11] [RL13]
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdv_reg <= 1'b0;
            rdd_reg <= '0;
        end else begin
            rdv_reg <= rdv_next;
            rdd_reg <= rdd_next;
        end
    end

    assign o_result_rd_valid = rdv_reg;
    assign o_result_rd_data  = rdd_reg;
endmodule : monitor_mux_adc_control

// ### core/monitor_pkg.sv
// types for the monitoring converter control
package monitor_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONVERT,
        ST_SETTLE
    } conv_state_t;
endpackage : monitor_pkg

// ### core/one_hot_selector.sv
// one-hot switch decode for one analog selector
`timescale 1ns/1ps
`include "monitor_consts.svh"
module one_hot_selector #(
    parameter int CODE_W = 6
) (
    input  wire logic [CODE_W-1:0]      i_code,
    input  wire logic                   i_enable,
    output logic [(1<<CODE_W)-2:0]      o_switch
);
    localparam int N_SW = (1 << CODE_W) - 1;

    // all-ones code has no switch so output floats
    genvar g;
    generate
        for (g = 0; g < N_SW; g++) begin : g_sw
            assign o_switch[g] = i_enable && (i_code == CODE_W'(g)); // [RL3] [RL2]
        end
    endgenerate
endmodule : one_hot_selector

// ### verification/monitor_comparator_model.sv
// comparator stand-in judging each trial code against a held level
`timescale 1ns/1ps
module monitor_comparator_model (
    input  wire logic        i_clk,
    input  wire logic [11:0] i_dac_code,
    input  wire logic [11:0] i_level,
    output logic             o_decision
);
    initial o_decision = 1'b0;
    // registered: decision moves just after an edge, like the latch
    always @(posedge i_clk) begin
        o_decision <= i_dac_code <= i_level;
    end
endmodule : monitor_comparator_model

// ### verification/monitor_ctl_props.sv
// checker on the monitor converter control ports
`timescale 1ns/1ps
module monitor_ctl_props #(
    parameter int DIV = 1024
) (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_cfg_wr,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [12:0] i_cfg_wdata,
    input wire logic        i_start_pulse,
    input wire logic        i_result_rd,
    input wire logic [12:0] o_cfg_rdata,
    input wire logic        o_monitor_enable,
    input wire logic [62:0] o_current_selector_sw,
    input wire logic [62:0] o_voltage_selector_sw,
    input wire logic        o_conv_clk_en,
    input wire logic        o_converter_start,
    input wire logic [11:0] o_dac_code,
    input wire logic        o_sample,
    input wire logic [11:0] o_conversion_result_reg,
    input wire logic        o_conv_done_n,
    input wire logic        o_result_rd_valid,
    input wire logic [11:0] o_result_rd_data
);
    int div_cnt;
    int conv_cnt;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    // counters kept here since repetition cannot span a divider period
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_cnt  <= 0;
            conv_cnt <= 0;
        end else begin
            div_cnt  <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
            conv_cnt <= o_converter_start ? 1 : conv_cnt + 1;
        end
    end
    property p_div; o_conv_clk_en |-> div_cnt == DIV - 1; endproperty
    a_div: assert property (p_div) else $error("tick period");
    property p_vsel; o_voltage_selector_sw == ((o_monitor_enable &&
        o_cfg_rdata[5:0] != 6'h3F) ? 63'h1 << o_cfg_rdata[5:0] : 63'h0);
    endproperty
    a_vsel: assert property (p_vsel) else $error("vsel decode");
    property p_isel; o_current_selector_sw == ((o_monitor_enable &&
        o_cfg_rdata[11:6] != 6'h3F) ? 63'h1 << o_cfg_rdata[11:6] : 63'h0);
    endproperty
    a_isel: assert property (p_isel) else $error("isel decode");
    property p_cfg; i_cfg_wr && i_cfg_addr == 8'h63 |=>
        o_cfg_rdata == $past(i_cfg_wdata); endproperty
    a_cfg: assert property (p_cfg) else $error("cfg write");
    property p_tick; o_converter_start |->
        $past(o_conv_clk_en) || o_conv_clk_en; endproperty
    a_tick: assert property (p_tick) else $error("start off tick");
    property p_samp; o_converter_start |->
        o_sample && o_dac_code == 12'h000; endproperty
    a_samp: assert property (p_samp) else $error("sample window");
    property p_msb; $fell(o_sample) |-> o_dac_code == 12'h800; endproperty
    a_msb: assert property (p_msb) else $error("msb trial");
    property p_busy; i_start_pulse && o_monitor_enable && !o_conv_done_n
        |=> o_conv_done_n; endproperty
    a_busy: assert property (p_busy) else $error("done not cleared");
    property p_len; $fell(o_conv_done_n) |->
        conv_cnt >= 14 * DIV - 1 && conv_cnt <= 14 * DIV + 1; endproperty
    a_len: assert property (p_len) else $error("conversion span");
    property p_rd; i_result_rd |=> o_result_rd_valid &&
        o_result_rd_data == $past(o_conversion_result_reg); endproperty
    a_rd: assert property (p_rd) else $error("result read");
    c_conv: cover property ($fell(o_conv_done_n));
    c_rd: cover property (o_result_rd_valid);
    c_off: cover property (o_monitor_enable && o_cfg_rdata[5:0] == 6'h3F);
endmodule : monitor_ctl_props
bind monitor_mux_adc_control monitor_ctl_props #(.DIV(DIV)) u_props (.*);

// ### verification/monitor_mux_adc_control_tb.sv
// self-checking bench for the monitor converter control
`timescale 1ns/1ps
module monitor_mux_adc_control_tb;
    localparam int DIV = 8;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [3:0]  stb = 4'h0;
    logic [7:0]  i_cfg_addr = 8'h63;
    logic [12:0] i_cfg_wdata = 13'h0000;
    logic [5:0]  i_trim_wdata = 6'h00;
    logic [11:0] vin = 12'h000;
    logic [12:0] m = 13'h0000;
    logic [12:0] fix [3] = '{13'h100E, 13'h1241, 13'h1FFF};
    logic [12:0] o_cfg_rdata;
    logic [5:0]  o_converter_trim_cfg;
    logic [62:0] o_current_selector_sw, o_voltage_selector_sw;
    logic [11:0] o_dac_code, o_conversion_result_reg, o_result_rd_data;
    logic        o_monitor_enable, o_conv_clk_en, o_converter_start;
    logic        o_sample, o_conv_done_n, o_result_rd_valid, i_comparator;
    int          num_errors = 0, check_count = 0, seed = 32'h8FD9, n, e;
    int          exp_q[$];
    wire         i_cfg_wr = stb[0];
    wire         i_trim_wr = stb[1];
    wire         i_start_pulse = stb[2];
    wire         i_result_rd = stb[3];
    monitor_mux_adc_control #(.DIV(DIV)) u_monitor_mux_adc_control (.*);
    monitor_comparator_model u_monitor_comparator_model (.i_clk(i_clk),
        .i_dac_code(o_dac_code), .i_level(vin), .o_decision(i_comparator));
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    function automatic logic [62:0] sw(input logic en, input logic [5:0] c);
        return (en && c != 6'h3F) ? 63'h1 << c : 63'h0;
    endfunction : sw
    task automatic check(input string what, input logic [62:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s exp %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic pulse(input int b, input logic [12:0] d = 13'h0000,
                         input logic [7:0] a = 8'h63);
        @(posedge i_clk);
        stb[b] <= 1'b1;
        i_cfg_addr <= a;
        if (b == 0) i_cfg_wdata <= d;
        if (b == 1) i_trim_wdata <= d[5:0];
        if (b == 2) vin <= d[11:0];
        @(posedge i_clk);
        stb[b] <= 1'b0;
        #1;
    endtask : pulse
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_resetn <= 1'b1;
        #1;
        check("cfg", o_cfg_rdata, 13'h0000);
        check("done", o_conv_done_n, 1'b1);
        check("trim", o_converter_trim_cfg, 6'h20);
        for (int k = 0; k < 12; k++) begin
            n = (k < 3) ? fix[k] : $random(seed);
            // k 3 goes to a neighbour address and must be dropped
            pulse(0, n[12:0], (k == 3) ? 8'h62 : 8'h63);
            if (k != 3) m = n[12:0];
            check("rdata", o_cfg_rdata, m);
            check("isw", o_current_selector_sw, sw(m[12], m[11:6]));
            check("vsw", o_voltage_selector_sw, sw(m[12], m[5:0]));
        end
        n = $random(seed);
        pulse(1, n[12:0]);
        check("trim", o_converter_trim_cfg, n[5:0]);
        pulse(0, 13'h100E);
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 32'hFFF : (k == 1) ? 0 : $random(seed);
            exp_q.push_back(n & 32'hFFF);
            pulse(2, n[12:0]);
            check("armed", o_conv_done_n, 1'b1);
            // refused restart while busy; level must not move under it
            pulse(2, {1'b0, vin});
            n = 0;
            while (o_conv_done_n !== 1'b0 && n < 16 * DIV) begin
                @(posedge i_clk);
                #1;
                n++;
            end
            check("span", n >= 14 * DIV - 1 && n <= 15 * DIV - 2, 1'b1);
            e = exp_q.pop_front();
            check("result", o_conversion_result_reg, e);
            pulse(3);
            check("rdv", o_result_rd_valid, 1'b1);
            check("rdd", o_result_rd_data, e);
            check("hold", o_conv_done_n, 1'b0);
        end
        pulse(0, 13'h000E);
        pulse(2, 13'h0123);
        repeat (16 * DIV) @(posedge i_clk);
        #1;
        check("off", o_conv_done_n, 1'b0);
        check("keep", o_conversion_result_reg, e);
        stop_test();
    end
endmodule : monitor_mux_adc_control_tb
